// ==== operand_pkg.sv ====
// Purpose: shared constants for the operand register file
// Assumes: 16-bit memory bus, 32-bit registers
// Notes: sizes, status word fields, op codes
package operand_pkg;
  // -------------------------------------------------------------------
  // operand sizes
  // -------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int LONG_W = 32;
  localparam int MSB_POS = 31;
  localparam int NUM_DATA = 8;
  localparam int NUM_ADDR = 8; // seven plus the user stack pointer
  localparam int USP_IDX = 7;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [15:0] STATUS_RESET = 16'h2700;
  // status word field positions (condition code byte is bits 7..0)
  localparam int CC_CARRY = 0;
  localparam int CC_OVFL = 1;
  localparam int CC_ZERO = 2;
  localparam int CC_NEG = 3;
  localparam int CC_EXTEND = 4;
  localparam logic [15:0] STATUS_MASK = 16'hA71F;
  localparam logic [7:0] CC_MASK = 8'h1F;
  localparam logic [31:0] LONG_STEP = 32'h0000_0002;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_NONE} size_e;
  typedef enum logic [3:0] {
    OP_NOP, OP_WRITE_DATA, OP_WRITE_ADDR, OP_READ_DATA, OP_READ_ADDR,
    OP_AND_CC, OP_OR_CC, OP_XOR_CC, OP_AND_SW, OP_OR_SW, OP_XOR_SW,
    OP_MOVE_TO_CC, OP_MOVE_TO_SW, OP_MOVE_FROM_SW, OP_USP_TO_REG,
    OP_REG_TO_USP
  } op_e;
  typedef enum logic [1:0] {MEM_IDLE, MEM_HIGH, MEM_LOW} mem_state_e;
endpackage : operand_pkg

// ==== operand_size.sv ====
// Purpose: size decode and operand sign/zero extension helper
// Assumes: purely combinational
// Notes: shared by data and address paths
`timescale 1ns/1ps
module operand_size
  import operand_pkg::*;
(
  input wire logic [1:0] size_field,
  input wire logic explicit_size,
  input wire op_e op,
  input wire logic [31:0] value,
  output size_e size,
  output logic [31:0] sign_ext,
  output logic [31:0] zero_ext
);
  // -------------------------------------------------------------------
  // size selection
  // -------------------------------------------------------------------
  // explicit or implied size
  always_comb begin
    if (explicit_size) begin
      size = size_e'(size_field);
    end else begin
      unique case (op)
        OP_AND_CC, OP_OR_CC, OP_XOR_CC, OP_MOVE_TO_CC: size = SZ_BYTE;
        OP_AND_SW, OP_OR_SW, OP_XOR_SW, OP_MOVE_TO_SW,
        OP_MOVE_FROM_SW: size = SZ_WORD;
        OP_USP_TO_REG, OP_REG_TO_USP: size = SZ_LONG;
        default: size = SZ_NONE; // no implied size for the rest
      endcase
    end
  end

  always_comb begin
    unique case (size)
      SZ_BYTE: begin
        sign_ext = {{(LONG_W-BYTE_W){value[BYTE_W-1]}}, value[BYTE_W-1:0]};
        zero_ext = {{(LONG_W-BYTE_W){1'b0}}, value[BYTE_W-1:0]};
      end
      SZ_WORD: begin
        sign_ext = {{(LONG_W-WORD_W){value[WORD_W-1]}}, value[WORD_W-1:0]};
        zero_ext = {{(LONG_W-WORD_W){1'b0}}, value[WORD_W-1:0]};
      end
      default: begin
        sign_ext = value;
        zero_ext = value;
      end
    endcase
  end
endmodule : operand_size

// ==== operand_regfile.sv ====
// Purpose: operand register file, status word and memory word sequencer
// Assumes: one operation per request, same clock as the core
// Notes: memory port is 16 bits wide, big-endian
//
// Contract
// - byte is 8 bits, word 16 bits, long word 32 bits.
// - size comes from the instruction field or from the operation.
// - eight data registers; seven address registers plus stack pointers; only the user stack pointer is kept.
// - byte in bits 7..0, word in 15..0, long fills the register.
// - bit 0 is least significant, bit 31 most significant.
// - byte or word writes to data registers keep the upper bits.
// - address registers are 32 bits and refuse byte operands.
// - address register source gives low word or all 32 bits.
// - address register destination is always written in full.
// - word ops to address registers sign-extend the operand first.
// - memory is big-endian; high byte at even address.
// - word and long accesses only at even addresses.
// - long word high half at n, low half at n plus two.
// - and, or, xor immediate to condition byte or status word.
// - moves from and to status word, to condition byte, user stack.
// - status word 16 bits; low byte holds X N Z V C.
`timescale 1ns/1ps
module operand_regfile
  import operand_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req,
  input wire op_e op,
  input wire logic [1:0] size_field,
  input wire logic explicit_size,
  input wire logic [2:0] reg_sel,
  input wire logic [31:0] operand,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  output logic [31:0] result,
  output logic done,
  output logic size_error,
  output logic align_error,
  output logic [15:0] status_word,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_strobe,
  output logic bus_write,
  output logic [1:0] bus_lane,
  output logic [7:0] bcd_high_digits
);
  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  // register banks
  logic [31:0] data_reg [NUM_DATA];
  logic [31:0] data_next [NUM_DATA];
  logic [31:0] addr_reg [NUM_ADDR];
  logic [31:0] addr_next [NUM_ADDR];
  logic [15:0] status_reg, status_next;
  logic [31:0] result_reg, result_next;
  logic done_reg, done_next;
  logic size_err_reg, size_err_next;
  logic align_err_reg, align_err_next;
  logic [7:0] bcd_reg, bcd_next;
  size_e size;
  logic [31:0] sign_ext;
  logic [31:0] zero_ext;
  logic [7:0] cc_in;

  operand_size u_size (
    .size_field(size_field),
    .explicit_size(explicit_size),
    .op(op),
    .value(operand),
    .size(size),
    .sign_ext(sign_ext),
    .zero_ext(zero_ext)
  );

  assign cc_in = operand[BYTE_W-1:0];

  // -------------------------------------------------------------------
  // register update
  // -------------------------------------------------------------------
  // one operation per request; errors reported without any write except the packed digit byte
  always_comb begin
    data_next = data_reg;
    addr_next = addr_reg;
    status_next = status_reg;
    result_next = result_reg;
    done_next = 1'b0;
    size_err_next = 1'b0;
    bcd_next = bcd_reg;
    if (req) begin
      done_next = 1'b1;
      unique case (op)
        OP_WRITE_DATA: begin
          unique case (size)
            SZ_BYTE: data_next[reg_sel][BYTE_W-1:0] = operand[BYTE_W-1:0];
            SZ_WORD: data_next[reg_sel][WORD_W-1:0] = operand[WORD_W-1:0];
            SZ_LONG: data_next[reg_sel] = operand;
            default: size_err_next = 1'b1;
          endcase
          bcd_next = {operand[7:4], operand[3:0]};
        end
        OP_WRITE_ADDR: begin
          if (size == SZ_BYTE || size == SZ_NONE) begin
            size_err_next = 1'b1;
          end else if (size == SZ_WORD) begin
            addr_next[reg_sel] = sign_ext;
          end else begin
            addr_next[reg_sel] = operand;
          end
        end
        OP_READ_DATA: begin
          if (size == SZ_NONE) begin
            size_err_next = 1'b1;
          end else begin
            result_next = (size == SZ_LONG) ? data_reg[reg_sel] :
              (size == SZ_WORD) ?
              {16'h0000, data_reg[reg_sel][WORD_W-1:0]} :
              {24'h00_0000, data_reg[reg_sel][BYTE_W-1:0]};
          end
        end
        OP_READ_ADDR: begin
          if (size == SZ_WORD) begin
            result_next = {16'h0000, addr_reg[reg_sel][WORD_W-1:0]};
          end else if (size == SZ_LONG) begin
            result_next = addr_reg[reg_sel];
          end else begin
            size_err_next = 1'b1;
          end
        end
        OP_AND_CC: status_next[7:0] = status_reg[7:0] & cc_in & CC_MASK;
        OP_OR_CC: status_next[7:0] = (status_reg[7:0] | cc_in) & CC_MASK;
        OP_XOR_CC: status_next[7:0] = (status_reg[7:0] ^ cc_in) & CC_MASK;
        OP_AND_SW:
          status_next = status_reg & operand[15:0] & STATUS_MASK;
        OP_OR_SW:
          status_next = (status_reg | operand[15:0]) & STATUS_MASK;
        OP_XOR_SW:
          status_next = (status_reg ^ operand[15:0]) & STATUS_MASK;
        OP_MOVE_TO_CC: status_next[7:0] = cc_in & CC_MASK;
        OP_MOVE_TO_SW: status_next = operand[15:0] & STATUS_MASK;
        OP_MOVE_FROM_SW: result_next = {16'h0000, status_reg};
        OP_USP_TO_REG: addr_next[reg_sel] = addr_reg[USP_IDX];
        OP_REG_TO_USP: addr_next[USP_IDX] = addr_reg[reg_sel];
        default: done_next = 1'b1;
      endcase
    end
  end

  // bit 31 down to bit 0
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_DATA; i++) begin
        data_reg[i] <= REG_RESET;
      end
      for (int i = 0; i < NUM_ADDR; i++) begin
        addr_reg[i] <= REG_RESET;
      end
      status_reg <= STATUS_RESET;
      result_reg <= REG_RESET;
      done_reg <= 1'b0;
      size_err_reg <= 1'b0;
      bcd_reg <= 8'h00;
    end else begin
      data_reg <= data_next;
      addr_reg <= addr_next;
      status_reg <= status_next;
      result_reg <= result_next;
      done_reg <= done_next;
      size_err_reg <= size_err_next;
      bcd_reg <= bcd_next;
    end
  end

  // -------------------------------------------------------------------
  // memory word sequencer
  // -------------------------------------------------------------------
  mem_state_e mem_state_reg, mem_state_next;
  logic [23:0] baddr_reg, baddr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] low_word_reg, low_word_next;
  logic strobe_reg, strobe_next;
  logic bwrite_reg, bwrite_next;
  logic [1:0] lane_reg, lane_next;
  logic long_reg, long_next;

  // long transfers go as two 16-bit halves, high half first; word transfers as one
  always_comb begin
    mem_state_next = mem_state_reg;
    baddr_next = baddr_reg;
    wdata_next = wdata_reg;
    low_word_next = low_word_reg;
    strobe_next = 1'b0;
    bwrite_next = bwrite_reg;
    lane_next = lane_reg;
    long_next = long_reg;
    align_err_next = 1'b0;
    unique case (mem_state_reg)
      MEM_IDLE: begin
        if (mem_req) begin
          // odd address refused for word and long
          if (mem_addr[0] && size != SZ_BYTE) begin
            align_err_next = 1'b1;
          end else begin
            lane_next = (size == SZ_BYTE) ?
              (mem_addr[0] ? 2'b01 : 2'b10) : 2'b11;
            baddr_next = mem_addr[23:0];
            bwrite_next = mem_write;
            long_next = (size == SZ_LONG);
            wdata_next = (size == SZ_LONG) ? operand[31:16] :
              (size == SZ_BYTE) ? {2{operand[7:0]}} : operand[15:0];
            low_word_next = operand[15:0];
            strobe_next = 1'b1;
            mem_state_next = MEM_HIGH;
          end
        end
      end
      MEM_HIGH: begin
        if (long_reg) begin
          // second word at n plus two
          baddr_next = baddr_reg + LONG_STEP[23:0];
          wdata_next = low_word_reg;
          low_word_next = mem_rdata;
          strobe_next = 1'b1;
          mem_state_next = MEM_LOW;
        end else begin
          mem_state_next = MEM_IDLE;
        end
      end
      MEM_LOW: mem_state_next = MEM_IDLE;
      default: mem_state_next = MEM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_state_reg <= MEM_IDLE;
      baddr_reg <= 24'h00_0000;
      wdata_reg <= 16'h0000;
      low_word_reg <= 16'h0000;
      strobe_reg <= 1'b0;
      bwrite_reg <= 1'b0;
      lane_reg <= 2'b00;
      long_reg <= 1'b0;
      align_err_reg <= 1'b0;
    end else begin
      mem_state_reg <= mem_state_next;
      baddr_reg <= baddr_next;
      wdata_reg <= wdata_next;
      low_word_reg <= low_word_next;
      strobe_reg <= strobe_next;
      bwrite_reg <= bwrite_next;
      lane_reg <= lane_next;
      long_reg <= long_next;
      align_err_reg <= align_err_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  // status word with condition byte low
  assign status_word = status_reg;
  assign result = result_reg;
  assign done = done_reg;
  assign size_error = size_err_reg;
  assign align_error = align_err_reg;
  assign bus_addr = baddr_reg;
  assign bus_wdata = wdata_reg;
  assign bus_strobe = strobe_reg;
  assign bus_write = bwrite_reg;
  assign bus_lane = lane_reg;
  assign bcd_high_digits = bcd_reg;
endmodule : operand_regfile

// ==== operand_regfile_properties.sv ====
// Purpose: port-level checks for the operand register file
// Assumes: one clock domain, async active-low reset
// Notes: stimulus keeps mem_req to idle moments only
`timescale 1ns/1ps
module operand_regfile_checker
  import operand_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req,
  input wire op_e op,
  input wire logic [1:0] size_field,
  input wire logic explicit_size,
  input wire logic [31:0] operand,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic done,
  input wire logic size_error,
  input wire logic align_error,
  input wire logic [15:0] status_word,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_strobe,
  input wire logic [1:0] bus_lane,
  input wire logic [7:0] bcd_high_digits
);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // long write: high half first, low half two bytes on
  sequence s_long_wr;
    mem_req && mem_write && explicit_size && size_field == 2'h2
      && !mem_addr[0];
  endsequence
  sequence s_two_words;
    bus_strobe && bus_addr == $past(mem_addr[23:0])
      && bus_wdata == $past(operand[31:16])
    ##1 bus_strobe && bus_addr == $past(mem_addr[23:0], 2) + 24'h2
      && bus_wdata == $past(operand[15:0], 2);
  endsequence
  a_done_follows: assert property (req |=> done)
    else $error("done missing after request");
  a_byte_addr_refused: assert property (req && op == OP_WRITE_ADDR
    && explicit_size && size_field == 2'h0 |=> size_error)
    else $error("byte write to address register not refused");
  a_long_two_words: assert property (s_long_wr |=> s_two_words)
    else $error("long write word order wrong");
  a_word_one_strobe: assert property (mem_req && explicit_size
    && size_field == 2'h1 && !mem_addr[0]
    |=> bus_strobe && bus_lane == 2'h3 ##1 !bus_strobe)
    else $error("word transfer strobe wrong");
  a_odd_refused: assert property (mem_req && explicit_size
    && size_field inside {2'h1, 2'h2} && mem_addr[0] |=> align_error)
    else $error("odd word address not refused");
  a_strobe_even: assert property (bus_strobe && bus_lane == 2'h3
    |-> !bus_addr[0])
    else $error("word strobe at odd address");
  a_status_mask: assert property ((status_word & ~STATUS_MASK) == 16'h0)
    else $error("status word holds unwritable bits");
  a_cc_and: assert property (req && op == OP_AND_CC && !explicit_size
    |=> status_word == ($past(status_word) & {8'hFF, $past(operand[7:0])}))
    else $error("and to condition byte wrong");
  a_bcd_low_byte: assert property (req && op == OP_WRITE_DATA
    && explicit_size && size_field != 2'h3
    |=> bcd_high_digits == $past(operand[7:0]))
    else $error("packed digit byte wrong");
endmodule : operand_regfile_checker

bind operand_regfile operand_regfile_checker u_chk (.clk, .reset_n, .req,
  .op, .size_field, .explicit_size, .operand, .mem_req, .mem_write,
  .mem_addr, .done, .size_error, .align_error, .status_word, .bus_addr,
  .bus_wdata, .bus_strobe, .bus_lane, .bcd_high_digits);

// ==== operand_regfile_tb_top.sv ====
// Purpose: self-checking bench for the operand register file
// Assumes: inputs change on the falling edge
// Notes: table rows first, then hand-written edge cases
`timescale 1ns/1ps
module operand_regfile_tb_top;
  import operand_pkg::*;
  typedef struct {op_e op; logic [1:0] sz; logic ex; logic [2:0] rs;
    logic [31:0] opd; logic [31:0] msk; logic [31:0] res;
    logic [15:0] sw;} row_s;
  logic clk, reset_n, req, explicit_size, mem_req, mem_write, done;
  logic size_error, align_error, bus_strobe, bus_write;
  op_e op;
  logic [1:0] size_field, bus_lane;
  logic [2:0] reg_sel;
  logic [31:0] operand, mem_addr, result;
  logic [15:0] status_word, bus_wdata;
  logic [23:0] bus_addr;
  logic [7:0] bcd_high_digits;
  int n_fail = 0;
  int num_checks = 0;
  // status ops use implied sizes, so ex is low there
  row_s rows[23] = '{
    '{OP_WRITE_DATA, 2, 1, 0, 32'h1234_5678, 0, 0, 16'h2700},
    '{OP_WRITE_DATA, 0, 1, 0, 32'hFFFF_FFAB, 0, 0, 16'h2700},
    '{OP_READ_DATA, 2, 1, 0, 0, 32'hFFFF_FFFF, 32'h1234_56AB, 16'h2700},
    '{OP_WRITE_DATA, 1, 1, 0, 32'hFFFF_CDEF, 0, 0, 16'h2700},
    '{OP_READ_DATA, 2, 1, 0, 0, 32'hFFFF_FFFF, 32'h1234_CDEF, 16'h2700},
    '{OP_WRITE_ADDR, 1, 1, 1, 32'h0000_8001, 0, 0, 16'h2700},
    '{OP_READ_ADDR, 2, 1, 1, 0, 32'hFFFF_FFFF, 32'hFFFF_8001, 16'h2700},
    '{OP_READ_ADDR, 1, 1, 1, 0, 32'h0000_FFFF, 32'h0000_8001, 16'h2700},
    '{OP_WRITE_ADDR, 2, 1, 7, 32'h8765_4321, 0, 0, 16'h2700},
    '{OP_READ_ADDR, 2, 1, 7, 0, 32'hFFFF_FFFF, 32'h8765_4321, 16'h2700},
    '{OP_MOVE_TO_CC, 0, 0, 0, 32'h0000_00FF, 0, 0, 16'h271F},
    '{OP_AND_CC, 0, 0, 0, 32'h0000_0015, 0, 0, 16'h2715},
    '{OP_OR_CC, 0, 0, 0, 32'h0000_000A, 0, 0, 16'h271F},
    '{OP_XOR_CC, 0, 0, 0, 32'h0000_0003, 0, 0, 16'h271C},
    '{OP_MOVE_TO_SW, 0, 0, 0, 32'h0000_FFFF, 0, 0, 16'hA71F},
    '{OP_AND_SW, 0, 0, 0, 32'h0000_2705, 0, 0, 16'h2705},
    '{OP_OR_SW, 0, 0, 0, 32'h0000_8000, 0, 0, 16'hA705},
    '{OP_XOR_SW, 0, 0, 0, 32'h0000_0001, 0, 0, 16'hA704},
    '{OP_MOVE_FROM_SW, 0, 0, 2, 0, 32'h0000_FFFF, 32'h0000_A704, 16'hA704},
    '{OP_USP_TO_REG, 0, 0, 2, 0, 0, 0, 16'hA704},
    '{OP_READ_ADDR, 2, 1, 2, 0, 32'hFFFF_FFFF, 32'h8765_4321, 16'hA704},
    '{OP_REG_TO_USP, 0, 0, 1, 0, 0, 0, 16'hA704},
    '{OP_READ_ADDR, 2, 1, 7, 0, 32'hFFFF_FFFF, 32'hFFFF_8001, 16'hA704}};

  operand_regfile u_operand_regfile (.clk(clk), .reset_n(reset_n),
    .req(req), .op(op), .size_field(size_field),
    .explicit_size(explicit_size), .reg_sel(reg_sel), .operand(operand),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_rdata(16'h0000), .result(result), .done(done),
    .size_error(size_error), .align_error(align_error),
    .status_word(status_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_strobe(bus_strobe), .bus_write(bus_write), .bus_lane(bus_lane),
    .bcd_high_digits(bcd_high_digits));

  // ------------------------------------------------------------
  // clock and tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // one request pulse; outputs are settled at the following fall
  task automatic do_op(input op_e o, input logic [1:0] s, input logic e,
    input logic [2:0] r, input logic [31:0] d);
    @(negedge clk);
    op = o; size_field = s; explicit_size = e; reg_sel = r; operand = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask : do_op

  task automatic mem_go(input logic [1:0] s, input logic [31:0] a,
    input logic [31:0] d);
    @(negedge clk);
    size_field = s; explicit_size = 1'b1; mem_addr = a; operand = d;
    mem_write = 1'b1; mem_req = 1'b1;
    @(negedge clk);
    mem_req = 1'b0;
  endtask : mem_go

  task automatic final_report;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs well under 200 cycles
  initial begin
    #(25 * 3000);
    n_fail++;
    final_report;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0; req = 1'b0; op = OP_NOP; size_field = 2'h0;
    explicit_size = 1'b0; reg_sel = 3'h0; operand = 32'h0;
    mem_req = 1'b0; mem_write = 1'b0; mem_addr = 32'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk({16'h0, status_word}, 32'h0000_2700);
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].sz, rows[i].ex, rows[i].rs, rows[i].opd);
      chk(result & rows[i].msk, rows[i].res);
      chk({31'h0, done}, 32'h1);
      chk({16'h0, status_word}, {16'h0, rows[i].sw});
    end
    // byte into an address register is refused, register kept
    do_op(OP_WRITE_ADDR, 2'h0, 1'b1, 3'h1, 32'h0000_00FF);
    chk({31'h0, size_error}, 32'h1);
    do_op(OP_READ_ADDR, 2'h2, 1'b1, 3'h1, 32'h0);
    chk(result, 32'hFFFF_8001);
    // packed digits keep the high digit in the upper nibble
    do_op(OP_WRITE_DATA, 2'h0, 1'b1, 3'h2, 32'h0000_0093);
    chk({24'h0, bcd_high_digits}, 32'h0000_0093);
    // long write: high word at n, low word at n plus two
    mem_go(2'h2, 32'h0000_0100, 32'hCAFE_BEEF);
    chk({bus_addr[15:0], bus_wdata}, 32'h0100_CAFE);
    chk({31'h0, bus_strobe}, 32'h1);
    @(negedge clk);
    chk({bus_addr[15:0], bus_wdata}, 32'h0102_BEEF);
    chk({31'h0, bus_strobe}, 32'h1);
    @(negedge clk);
    chk({31'h0, bus_strobe}, 32'h0);
    // word write then odd-address word refused
    mem_go(2'h1, 32'h0000_0200, 32'h0000_1234);
    chk({bus_strobe, bus_lane, bus_addr}, {1'b1, 2'h3, 24'h200, 5'h0} >> 5);
    chk({15'h0, bus_write, bus_wdata}, 32'h0001_1234);
    @(negedge clk);
    mem_go(2'h1, 32'h0000_0201, 32'h0000_1234);
    chk({align_error, bus_strobe}, 32'h2);
    // odd byte goes on the lower lane, no alignment error
    mem_go(2'h0, 32'h0000_0203, 32'h0000_00A5);
    chk({14'h0, bus_lane, bus_wdata}, 32'h0001_A5A5);
    chk({align_error, bus_strobe}, 32'h1);
    // reset in mid-run: outputs back to their reset values
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    chk({status_word, 15'h0, done}, 32'h2700_0000);
    reset_n = 1'b1;
    do_op(OP_READ_ADDR, 2'h2, 1'b1, 3'h7, 32'h0);
    chk(result, 32'h0000_0000);
    final_report;
  end
endmodule : operand_regfile_tb_top
